/* File: common/jcp_params.svh */
/*
  constants of the character port register block: offsets, field positions,
  reset values and thresholds. assumes inclusion by bare name.
*/
`ifndef JCP_PARAMS_SVH
`define JCP_PARAMS_SVH

// ----------------------------------------
// register indices (word offsets)
// ----------------------------------------
`define JCP_IDX_DATA 1'h0
`define JCP_IDX_CTRL 1'h1

// ----------------------------------------
// field positions
// ----------------------------------------
`define JCP_CHAR_MSB 7
`define JCP_RVALID_BIT 15
`define JCP_RX_IE_BIT 0
`define JCP_TX_IE_BIT 1
`define JCP_RX_IP_BIT 8
`define JCP_TX_IP_BIT 9
`define JCP_ACT_BIT 10
`define JCP_COUNT_LSB 16

// ----------------------------------------
// defaults
// ----------------------------------------
`define JCP_FIFO_DEPTH 8
`define JCP_THRESH_DEF 8
`define JCP_RDATA_RST 32'h0000_0000

`endif

/* File: common/jcp_pkg.sv */
/*
  types shared by the character port register block.
  assumes nothing beyond a SystemVerilog compiler.
*/
package jcp_pkg;
  typedef logic [7:0] jcp_char_t;
  typedef logic [31:0] jcp_word_t;
endpackage : jcp_pkg

/* File: verilog/jcp_fifo.sv */
/*
  synchronous FIFO with valid/ready on both sides; read data from a register
  (first-word fall-through register stage). assumes one clock, sync reset.
*/
module jcp_fifo
  import jcp_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int CW = $clog2(DEPTH + 1)
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_wdata,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [WIDTH-1:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [CW-1:0] o_count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic wready_r;
  logic rvalid_r;

  wire do_wr = i_wvalid && o_wready;
  wire do_rd = i_rready && o_rvalid;
  wire [AW-1:0] rp_inc = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + 1'b1;
  wire [AW-1:0] wp_inc = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + 1'b1;

  wire [CW-1:0] cnt_nxt = cnt_r + CW'(do_wr) - CW'(do_rd);

  // flags kept in flops so both handshake outputs leave straight from a register
  assign o_wready = wready_r;
  assign o_rvalid = rvalid_r;
  assign o_count = cnt_r;

  // head word read from a register; mem written only at wp
  always_ff @(posedge i_clk)
  begin
    if (do_wr)
      mem_r[wp_r] <= i_wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= '0;
    else if (do_wr && (cnt_r == '0 || (cnt_r == CW'(1) && do_rd)))
      o_rdata <= i_wdata;
    else if (do_rd)
      o_rdata <= mem_r[rp_inc];
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      wready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
    else
    begin
      if (do_wr)
        wp_r <= wp_inc;
      if (do_rd)
        rp_r <= rp_inc;
      cnt_r <= cnt_nxt;
      wready_r <= (cnt_nxt != CW'(DEPTH));
      rvalid_r <= (cnt_nxt != '0);
    end
  end
endmodule // jcp_fifo

/* File: verilog/jcp_regs.sv */
/*
  register, FIFO and interrupt logic of the JTAG character port, bus side.
  assumes a simple word-indexed register port and a link-side transport on
  the same clock that streams characters with valid/ready.
*/
`include "jcp_params.svh"

module jcp_regs
  import jcp_pkg::*;
#(
  parameter int DEPTH = `JCP_FIFO_DEPTH,
  parameter int WR_THRESH = `JCP_THRESH_DEF,
  parameter int RD_THRESH = `JCP_THRESH_DEF
)
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [31:0] i_wdata,
  output logic [31:0] o_rdata,
  output logic o_irq,
  output logic [7:0] o_link_tx_data,
  output logic o_link_tx_valid,
  input wire logic i_link_tx_ready,
  input wire logic [7:0] i_link_rx_data,
  input wire logic i_link_rx_valid,
  output logic o_link_rx_ready,
  input wire logic i_link_poll,
  input wire logic i_link_rx_idle
);
  localparam int CW = $clog2(DEPTH + 1);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // free entries of a FIFO of DEPTH words
  function automatic logic [CW-1:0] free_of(input logic [CW-1:0] cnt);
    return CW'(DEPTH) - cnt;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic rx_irq_enable_r;
  logic tx_irq_enable_r;
  logic host_activity_flag_r;
  logic irq_r;
  logic [7:0] tx_head;
  logic tx_head_v;
  logic tx_ready;
  logic [CW-1:0] tx_cnt;
  logic [7:0] rx_head;
  logic rx_head_v;
  logic rx_ready;
  logic [CW-1:0] rx_cnt;
  logic [CW-1:0] tx_cnt_q;
  logic [CW-1:0] rx_cnt_q;
  logic rd_pop_q;
  logic pop_bad_q;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire sel_data = (i_addr == `JCP_IDX_DATA);
  wire sel_ctrl = (i_addr == `JCP_IDX_CTRL);
  wire data_wr = i_wr && sel_data;
  wire data_rd = i_rd && sel_data;
  wire ctrl_wr = i_wr && sel_ctrl;
  wire rx_pop = data_rd && rx_head_v;
  wire [CW-1:0] rx_left = rx_cnt - CW'(rx_pop);
  wire [CW-1:0] tx_free = free_of(tx_cnt);
  wire [CW-1:0] rx_free = free_of(rx_cnt);

  // thresholds fixed at build time; software cannot move them
  wire tx_cond = (tx_cnt <= CW'(WR_THRESH));
  wire rx_cond = (rx_free <= CW'(RD_THRESH))
    || (rx_head_v && i_link_rx_idle);
  wire rx_irq_pending = rx_cond && rx_irq_enable_r;
  wire tx_irq_pending = tx_cond && tx_irq_enable_r;
  wire irq_nxt = rx_irq_pending || tx_irq_pending;
  wire clear_act = ctrl_wr && i_wdata[`JCP_ACT_BIT];
  // set wins over a simultaneous clear so no poll is lost
  wire act_nxt = i_link_poll ? 1'b1 : (clear_act ? 1'b0 : host_activity_flag_r);

  // ----------------------------------------
  // read mux; reserved bits read zero
  // ----------------------------------------
  jcp_word_t data_word;
  jcp_word_t ctrl_word;
  jcp_word_t rdata_nxt;
  always_comb
  begin
    data_word = '0;
    data_word[`JCP_CHAR_MSB:0] = rx_head_v ? rx_head : 8'h00;
    data_word[`JCP_RVALID_BIT] = rx_head_v;
    data_word[`JCP_COUNT_LSB +: CW] = rx_left;
    ctrl_word = '0;
    ctrl_word[`JCP_RX_IE_BIT] = rx_irq_enable_r;
    ctrl_word[`JCP_TX_IE_BIT] = tx_irq_enable_r;
    ctrl_word[`JCP_RX_IP_BIT] = rx_irq_pending;
    ctrl_word[`JCP_TX_IP_BIT] = tx_irq_pending;
    ctrl_word[`JCP_ACT_BIT] = host_activity_flag_r;
    ctrl_word[`JCP_COUNT_LSB +: CW] = tx_free;
    rdata_nxt = sel_data ? data_word : ctrl_word;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rdata <= `JCP_RDATA_RST;
    else if (i_rd)
      o_rdata <= rdata_nxt;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rx_irq_enable_r <= 1'b0;
      tx_irq_enable_r <= 1'b0;
      host_activity_flag_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        rx_irq_enable_r <= i_wdata[`JCP_RX_IE_BIT];
        tx_irq_enable_r <= i_wdata[`JCP_TX_IE_BIT];
      end
      host_activity_flag_r <= act_nxt;
      irq_r <= irq_nxt;
    end
  end
  assign o_irq = irq_r;

  // ----------------------------------------
  // FIFOs: tx filled by bus, drained by link; rx the other way
  // ----------------------------------------
  // write never stalls: if full, wvalid meets a low wready and is dropped
  jcp_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_tx_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wdata(i_wdata[`JCP_CHAR_MSB:0]),
    .i_wvalid(data_wr),
    .o_wready(tx_ready),
    .o_rdata(tx_head),
    .o_rvalid(tx_head_v),
    .i_rready(i_link_tx_ready),
    .o_count(tx_cnt)
  );
  assign o_link_tx_data = tx_head;
  assign o_link_tx_valid = tx_head_v;

  // link must hold valid until ready; rx_ready stalls the link when full
  jcp_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_rx_fifo (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_wdata(i_link_rx_data),
    .i_wvalid(i_link_rx_valid),
    .o_wready(rx_ready),
    .o_rdata(rx_head),
    .o_rvalid(rx_head_v),
    .i_rready(rx_pop),
    .o_count(rx_cnt)
  );
  assign o_link_rx_ready = rx_ready;

  // ----------------------------------------
  // assertion helpers
  // ----------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      tx_cnt_q <= '0;
      rx_cnt_q <= '0;
      rd_pop_q <= 1'b0;
      pop_bad_q <= 1'b0;
    end
    else
    begin
      tx_cnt_q <= tx_cnt;
      rx_cnt_q <= rx_cnt;
      rd_pop_q <= rx_pop;
      pop_bad_q <= data_rd && !rx_head_v;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_tx_push_count: assert property (
    data_wr && tx_ready && !(tx_head_v && i_link_tx_ready) |=> tx_cnt == $past(tx_cnt) + 1'b1)
    else $error("tx write did not add one character");
  a_tx_full_drop: assert property (
    data_wr && !tx_ready && !i_link_tx_ready |=> tx_cnt == tx_cnt_q && tx_cnt == CW'(DEPTH))
    else $error("write into full tx FIFO changed it");
  a_rx_pop_data: assert property (
    data_rd && rx_head_v |=> o_rdata[`JCP_CHAR_MSB:0] == $past(rx_head))
    else $error("data read returned wrong character");
  a_rvalid_flag: assert property (
    data_rd |=> o_rdata[`JCP_RVALID_BIT] == $past(rx_head_v))
    else $error("valid flag mismatch");
  a_rx_left: assert property (
    rd_pop_q && !$past(i_link_rx_valid && rx_ready) |-> o_rdata[`JCP_COUNT_LSB +: CW] == rx_cnt)
    else $error("chars left field wrong");
  a_empty_read: assert property (
    pop_bad_q |-> o_rdata[`JCP_RVALID_BIT] == 1'b0 && rx_cnt >= rx_cnt_q)
    else $error("empty read disturbed FIFO");
  a_ctrl_enable: assert property (
    ctrl_wr |=> rx_irq_enable_r == $past(i_wdata[`JCP_RX_IE_BIT])
      && tx_irq_enable_r == $past(i_wdata[`JCP_TX_IE_BIT]))
    else $error("enable bits not stored");
  a_act_sticky: assert property (
    i_link_poll |=> host_activity_flag_r ##1 (host_activity_flag_r || $past(clear_act)))
    else $error("activity flag not sticky");
  a_act_clear: assert property (
    clear_act && !i_link_poll |=> !host_activity_flag_r)
    else $error("activity flag not cleared");
  a_tx_free: assert property (
    i_rd && sel_ctrl |=> o_rdata[`JCP_COUNT_LSB +: CW] == CW'(DEPTH) - tx_cnt_q)
    else $error("tx free field wrong");
  a_irq_follow: assert property (
    (rx_irq_pending || tx_irq_pending) |=> o_irq)
    else $error("irq not raised");
  a_irq_quiet: assert property (
    !rx_irq_enable_r && !tx_irq_enable_r |=> !o_irq)
    else $error("irq raised while disabled");
  a_tx_thresh: assert property (
    tx_irq_enable_r && tx_cnt > CW'(WR_THRESH) |-> !ctrl_word[`JCP_TX_IP_BIT])
    else $error("tx pending above threshold");

  // ----------------------------------------
  // assertions: FIFO counts, flags, read data
  // ----------------------------------------
  a_tx_pop_count: assert property (
    !data_wr && tx_head_v && i_link_tx_ready |=> tx_cnt == $past(tx_cnt) - 1'b1)
    else $error("tx pop did not remove one character");
  a_tx_push_pop: assert property (
    data_wr && tx_ready && tx_head_v && i_link_tx_ready |=> tx_cnt == $past(tx_cnt))
    else $error("tx push with pop changed count");
  a_tx_head_first: assert property (
    data_wr && tx_ready && !tx_head_v |=> tx_head_v && tx_head == $past(i_wdata[`JCP_CHAR_MSB:0]))
    else $error("first tx character not at head");
  a_rx_push_count: assert property (
    i_link_rx_valid && rx_ready && !rx_pop |=> rx_cnt == $past(rx_cnt) + 1'b1)
    else $error("rx push did not add one character");
  a_rx_pop_count: assert property (
    rx_pop && !(i_link_rx_valid && rx_ready) |=> rx_cnt == $past(rx_cnt) - 1'b1)
    else $error("rx pop did not remove one character");
  a_tx_valid_match: assert property (
    tx_head_v == (tx_cnt != '0))
    else $error("tx valid flag disagrees with count");
  a_rx_ready_match: assert property (
    rx_ready == (rx_cnt != CW'(DEPTH)))
    else $error("rx ready flag disagrees with count");
  a_tx_bound: assert property (
    tx_cnt <= CW'(DEPTH))
    else $error("tx count above depth");
  a_rx_bound: assert property (
    rx_cnt <= CW'(DEPTH))
    else $error("rx count above depth");
  a_rx_thresh: assert property (
    rx_irq_enable_r && !i_link_rx_idle && rx_free > CW'(RD_THRESH) |-> !ctrl_word[`JCP_RX_IP_BIT])
    else $error("rx pending with room left");
  a_rx_near_full: assert property (
    rx_irq_enable_r && rx_free <= CW'(RD_THRESH) |-> ctrl_word[`JCP_RX_IP_BIT])
    else $error("rx pending missing near full");
  a_rx_idle_host: assert property (
    rx_irq_enable_r && rx_head_v && i_link_rx_idle |-> ctrl_word[`JCP_RX_IP_BIT])
    else $error("rx pending missing on idle host");
  a_tx_low_fill: assert property (
    tx_irq_enable_r && tx_cnt <= CW'(WR_THRESH) |-> ctrl_word[`JCP_TX_IP_BIT])
    else $error("tx pending missing at low fill");
  a_rx_pend_gated: assert property (
    !rx_irq_enable_r |-> !ctrl_word[`JCP_RX_IP_BIT])
    else $error("rx pending while disabled");
  a_tx_pend_gated: assert property (
    !tx_irq_enable_r |-> !ctrl_word[`JCP_TX_IP_BIT])
    else $error("tx pending while disabled");
  a_irq_drop: assert property (
    !rx_irq_pending && !tx_irq_pending |=> !o_irq)
    else $error("irq stays up with nothing pending");
  a_act_hold: assert property (
    host_activity_flag_r && !clear_act |=> host_activity_flag_r)
    else $error("activity flag lost without clear");
  a_act_set_win: assert property (
    i_link_poll && clear_act |=> host_activity_flag_r)
    else $error("clear beat a simultaneous poll");
  a_act_idle: assert property (
    !host_activity_flag_r && !i_link_poll |=> !host_activity_flag_r)
    else $error("activity flag set without poll");
  a_ctrl_keep: assert property (
    !ctrl_wr |=> rx_irq_enable_r == $past(rx_irq_enable_r)
      && tx_irq_enable_r == $past(tx_irq_enable_r))
    else $error("enable bits moved without write");
  a_rdata_hold: assert property (
    !i_rd |=> $stable(o_rdata))
    else $error("read data changed without read");
  a_data_reserved: assert property (
    data_rd |=> o_rdata[`JCP_RVALID_BIT-1:`JCP_CHAR_MSB+1] == '0)
    else $error("reserved data bits not zero");
  a_ctrl_reserved: assert property (
    i_rd && sel_ctrl |=> o_rdata[`JCP_RX_IP_BIT-1:`JCP_TX_IE_BIT+1] == '0)
    else $error("reserved control bits not zero");
  a_rst_quiet: assert property (disable iff (1'b0)
    i_rst |=> !irq_r && !tx_head_v && rx_ready && !host_activity_flag_r && !rx_head_v)
    else $error("reset left state behind");
  a_empty_keep: assert property (
    data_rd && !rx_head_v && !i_link_rx_valid |=> rx_cnt == $past(rx_cnt))
    else $error("empty read changed rx count");

  c_tx_full_drop: cover property (data_wr && !tx_ready);
  c_rx_pop: cover property (rx_pop ##1 rx_pop);
  c_irq_on: cover property (!o_irq ##1 o_irq);
  c_rx_idle: cover property (rx_irq_enable_r && rx_head_v && i_link_rx_idle);
  c_act_clear: cover property (host_activity_flag_r ##1 clear_act ##1 !host_activity_flag_r);
endmodule // jcp_regs

/* File: verif/jcp_link_model.sv */
/*
  link-side model of the character port: takes tx characters, offers rx ones.
  assumes the block's link ports on the same clock, sync active-high reset.
*/
module jcp_link_model
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_tx_data,
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  output logic [7:0] o_rx_data,
  output logic o_rx_valid,
  input wire logic i_rx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic stall;
  logic [7:0] got_q[$];
  // ----------------------------------------
  // tx sink
  // ----------------------------------------
  assign o_tx_ready = !stall;
  initial
  begin
    stall = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_data = 8'hFF;
  end
  always @(posedge i_clk)
    if (!i_rst && i_tx_valid && o_tx_ready)
      got_q.push_back(i_tx_data);
  // ----------------------------------------
  // rx source
  // ----------------------------------------
  // held until ready is seen at an edge; afterwards the data lines invert
  task automatic send(input logic [7:0] c, output bit ok);
    int n;
    n = 0;
    @(posedge i_clk);
    #1 o_rx_valid = 1'b1;
    o_rx_data = c;
    while (i_rx_ready !== 1'b1 && n < 50)
    begin
      @(posedge i_clk);
      #1 n++;
    end
    ok = (n < 50);
    @(posedge i_clk);
    #1 o_rx_valid = 1'b0;
    o_rx_data = ~c;
  endtask
endmodule // jcp_link_model

/* File: verif/jcp_regs_tb_top.sv */
/*
  self-checking bench of the character port register block.
  assumes jcp_regs with thresholds of 2 and the link model of this folder.
*/
module jcp_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_clk, i_rst, i_addr, i_rd, i_wr, i_link_poll, i_link_rx_idle;
  logic [31:0] i_wdata, o_rdata, rd;
  logic o_irq, tx_valid, tx_ready, rx_valid, rx_ready;
  logic [7:0] tx_data, rx_data;
  int n_fail, num_checks;
  bit ok;
  jcp_regs #(.DEPTH(8), .WR_THRESH(2), .RD_THRESH(2)) uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq(o_irq), .o_link_tx_data(tx_data),
    .o_link_tx_valid(tx_valid), .i_link_tx_ready(tx_ready), .i_link_rx_data(rx_data),
    .i_link_rx_valid(rx_valid), .o_link_rx_ready(rx_ready), .i_link_poll(i_link_poll),
    .i_link_rx_idle(i_link_rx_idle));
  jcp_link_model lnk (.i_clk(i_clk), .i_rst(i_rst), .i_tx_data(tx_data), .i_tx_valid(tx_valid),
    .o_tx_ready(tx_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tmo();
    n_fail++;
    $display("BAD %0t wait ran out", $time);
    tally_and_finish();
  endtask
  task automatic bus_wr(input logic a, input logic [31:0] d);
    @(posedge i_clk);
    #1 i_wr = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(posedge i_clk);
    #1 i_wr = 1'b0;
  endtask
  // data is taken after the edge that registers it
  task automatic bus_rd(input logic a, output logic [31:0] d);
    @(posedge i_clk);
    #1 i_rd = 1'b1;
    i_addr = a;
    @(posedge i_clk);
    #1 i_rd = 1'b0;
    d = o_rdata;
  endtask
  task automatic drain(input int n);
    int k;
    k = 0;
    while (lnk.got_q.size() < n && k < 40)
    begin
      @(posedge i_clk);
      k++;
    end
    if (k == 40)
      tmo();
    repeat (3) @(posedge i_clk);
    #1 chk(lnk.got_q.size(), n, "tx count at link");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    bus_rd(0, rd);
    chk(rd, 32'h0000_0000, "empty data read");
    bus_rd(1, rd);
    chk(rd, 32'h0008_0000, "control after reset");
    chk({29'h0, o_irq, tx_valid, rx_ready}, 32'h0000_0001, "link and irq idle");
    $display("t_reset done");
  endtask
  task automatic t_tx_fill;
    lnk.stall = 1'b1;
    for (int k = 0; k < 9; k++)
    begin
      bus_wr(0, 32'h0000_0041 + k);
      bus_rd(1, rd);
      chk(rd, (k < 8) ? (32'(7 - k) << 16) : 32'h0, "tx free");
    end
    lnk.stall = 1'b0;
    drain(8);
    for (int k = 0; k < 8; k++)
      chk(lnk.got_q[k], 32'h0000_0041 + k, "tx order");
    $display("t_tx_fill done");
  endtask
  task automatic t_tx_irq;
    lnk.got_q.delete();
    bus_wr(1, 32'h0000_0002);
    bus_rd(1, rd);
    chk(rd, 32'h0008_0202, "tx pending when empty");
    chk(o_irq, 32'h1, "irq on tx");
    lnk.stall = 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      bus_wr(0, 32'h0000_0061 + k);
      bus_rd(1, rd);
      chk(rd, (k < 2) ? (32'(7 - k) << 16) | 32'h202 : 32'h0005_0002, "tx threshold");
    end
    chk(o_irq, 32'h0, "irq off above tx threshold");
    bus_wr(1, 32'h0000_0000);
    lnk.stall = 1'b0;
    drain(3);
    chk(lnk.got_q[2], 32'h0000_0063, "last tx char");
    $display("t_tx_irq done");
  endtask
  task automatic t_rx;
    for (int k = 0; k < 8; k++)
    begin
      lnk.send(8'hA0 + 8'(k), ok);
      if (!ok)
        tmo();
    end
    chk(rx_ready, 32'h0, "rx full refuses");
    bus_wr(1, 32'h0000_0001);
    bus_rd(1, rd);
    chk(rd, 32'h0008_0101, "rx pending near full");
    chk(o_irq, 32'h1, "irq on rx");
    for (int k = 0; k < 8; k++)
    begin
      bus_rd(0, rd);
      chk(rd, {16'(7 - k), 8'h80, 8'(8'hA0 + k)}, "rx char");
      bus_rd(1, rd);
      chk(rd[8], k < 2, "rx pending after read");
    end
    bus_rd(0, rd);
    chk(rd, 32'h0000_0000, "empty read");
    lnk.send(8'hC3, ok);
    if (!ok)
      tmo();
    @(posedge i_clk);
    #1 i_link_rx_idle = 1'b1;
    bus_rd(1, rd);
    chk(rd, 32'h0008_0101, "rx pending on idle host");
    @(posedge i_clk);
    #1 i_link_rx_idle = 1'b0;
    bus_rd(1, rd);
    chk(rd, 32'h0008_0001, "no pending when host busy");
    bus_rd(0, rd);
    chk(rd, 32'h0000_80C3, "single rx char");
    bus_wr(1, 32'h0000_0000);
    $display("t_rx done");
  endtask
  task automatic t_activity;
    @(posedge i_clk);
    #1 i_link_poll = 1'b1;
    @(posedge i_clk);
    #1 i_link_poll = 1'b0;
    bus_rd(1, rd);
    chk(rd, 32'h0008_0400, "activity set");
    bus_wr(1, 32'h0000_0000);
    bus_rd(1, rd);
    chk(rd, 32'h0008_0400, "activity kept on zero write");
    bus_wr(1, 32'h0000_0400);
    bus_rd(1, rd);
    chk(rd, 32'h0008_0000, "activity cleared");
    $display("t_activity done");
  endtask
  // ----------------------------------------
  // clock, reset, sequence
  // ----------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  initial
  begin
    {i_rst, i_addr, i_rd, i_wr, i_link_poll, i_link_rx_idle} = 6'h20;
    i_wdata = 32'h0;
    repeat (8) @(posedge i_clk);
    #1 i_rst = 1'b0;
    t_reset();
    t_tx_fill();
    t_tx_irq();
    t_rx();
    t_activity();
    tally_and_finish();
  end
endmodule // jcp_regs_tb_top
